// *** common/cpu_decode_pkg.sv ***
// Purpose: Shared opcodes, classes and timing for the move/bit/branch decoder
// Assumes: 8-bit opcodes, 16-bit program counter
// Notes:   Opcodes outside the decoded groups map to class cl_other
package cpu_decode_pkg;

  // ----------------------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    cl_nop, cl_load_dir, cl_load_ind, cl_xdata_read, cl_push, cl_pop,
    cl_swap_dir, cl_bit_inv, cl_and_c, cl_and_nc, cl_or_c, cl_or_nc,
    cl_bit_to_c, cl_c_to_bit, cl_absolute_call, cl_long_call, cl_ret,
    cl_interrupt_return, cl_absolute_jump, cl_long_jump, cl_short_jump,
    cl_bit_test_clear_branch, cl_jump_data_pointer_16, cl_jump_zero, cl_jump_nonzero,
    cl_compare_branch_unequal, cl_decrement_branch_nonzero, cl_other
  } class_e;

  // Encoded 0, 1, 3 in sequence: opcode -> operands -> execute -> opcode
  typedef enum logic [1:0] {
    st_opcode = 2'h0,
    st_args   = 2'h1,
    st_exec   = 2'h3
  } state_e;

  // ----------------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_NOP        = 8'h00;
  localparam logic [7:0] OP_LOAD_DIR   = 8'he5;
  localparam logic [6:0] OP_LOAD_IND   = 7'h73;
  localparam logic [7:0] OP_XDATA_RD   = 8'hf0;
  localparam logic [7:0] OP_PUSH       = 8'hc0;
  localparam logic [7:0] OP_POP        = 8'hd0;
  localparam logic [7:0] OP_SWAP_DIR   = 8'hc5;
  localparam logic [7:0] OP_BIT_INV    = 8'hb2;
  localparam logic [7:0] OP_AND_C      = 8'h82;
  localparam logic [7:0] OP_AND_NC     = 8'hb0;
  localparam logic [7:0] OP_OR_C       = 8'h72;
  localparam logic [7:0] OP_OR_NC      = 8'ha0;
  localparam logic [7:0] OP_BIT_TO_C   = 8'ha2;
  localparam logic [7:0] OP_C_TO_BIT   = 8'h92;
  localparam logic [4:0] OP_ABS_CALL   = 5'h11;
  localparam logic [4:0] OP_ABS_JUMP   = 5'h01;
  localparam logic [7:0] OP_LONG_CALL  = 8'h12;
  localparam logic [7:0] OP_RET        = 8'h22;
  localparam logic [7:0] OP_INT_RET    = 8'h32;
  localparam logic [7:0] OP_LONG_JUMP  = 8'h02;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_BTC_BRANCH = 8'h10;
  localparam logic [7:0] OP_JUMP_DATA_POINTER_16  = 8'h73;
  localparam logic [7:0] OP_JUMP_ZERO  = 8'h60;
  localparam logic [7:0] OP_JUMP_NZ    = 8'h70;
  localparam logic [4:0] OP_CMP_REG    = 5'h17;
  localparam logic [7:0] OP_DEC_BRANCH = 8'hd5;

  // ----------------------------------------------------------------------
  // Lengths, timing and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [1:0] MC_1  = 2'h1;
  localparam logic [1:0] MC_2  = 2'h2;
  localparam int         CLK_PER_MC = 2;
  localparam logic [15:0] RESET_PC  = 16'h0000;
  localparam logic [7:0]  DECREMENT_BRANCH_NONZERO_LAST = 8'h01;

endpackage : cpu_decode_pkg

// *** common/decode_if.sv ***
// Purpose: Carries an opcode to the lookup table and its decode back
// Assumes: Purely combinational lookup
// Notes:   core drives opcode, table answers
`timescale 1ns/10ps
`default_nettype none
interface decode_if;
  logic [7:0]                opcode;
  cpu_decode_pkg::class_e    cls;
  logic [1:0]                len;
  logic [1:0]                cyc;
  logic [2:0]                reg_sel;
  modport table_end (input opcode, output cls, len, cyc, reg_sel);
  modport core_end  (output opcode, input cls, len, cyc, reg_sel);
endinterface : decode_if
`default_nettype wire

// *** rtl/mcycle_tick.sv ***
// Purpose: Machine cycle enable, one pulse every CLK_PER_MC clocks
// Assumes: run held high for the whole execute phase
// Notes:   Phase restarts whenever run drops
`timescale 1ns/10ps
`default_nettype none
module mcycle_tick (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic run,
  output wire logic tick
);
  logic phase;

  always_ff @(posedge clk) begin
    if (srst || !run) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  assign tick = run & phase;
endmodule : mcycle_tick
`default_nettype wire

// *** rtl/opcode_table.sv ***
// Purpose: Opcode to class, length, machine cycles and register select
// Assumes: Combinational, no state
// Notes:   Unlisted opcodes are one byte, one machine cycle, class other
`timescale 1ns/10ps
`default_nettype none
module opcode_table (
  decode_if.table_end dif
);
  logic [7:0] op;
  assign op = dif.opcode;
  assign dif.reg_sel = op[2:0];

  always_comb begin
    dif.cls = cpu_decode_pkg::cl_other;
    dif.len = cpu_decode_pkg::LEN_1;
    dif.cyc = cpu_decode_pkg::MC_1;
    if (op[4:0] == cpu_decode_pkg::OP_ABS_CALL) begin
      dif.cls = cpu_decode_pkg::cl_absolute_call;
      dif.len = cpu_decode_pkg::LEN_2;
      dif.cyc = cpu_decode_pkg::MC_2;
    end else if (op[4:0] == cpu_decode_pkg::OP_ABS_JUMP) begin
      dif.cls = cpu_decode_pkg::cl_absolute_jump;
      dif.len = cpu_decode_pkg::LEN_2;
      dif.cyc = cpu_decode_pkg::MC_2;
    end else if (op[7:1] == cpu_decode_pkg::OP_LOAD_IND) begin
      dif.cls = cpu_decode_pkg::cl_load_ind;
    end else if (op[7:3] == cpu_decode_pkg::OP_CMP_REG) begin
      dif.cls = cpu_decode_pkg::cl_compare_branch_unequal;
      dif.len = cpu_decode_pkg::LEN_3;
      dif.cyc = cpu_decode_pkg::MC_2;
    end else begin
      case (op)
        cpu_decode_pkg::OP_NOP: begin
          dif.cls = cpu_decode_pkg::cl_nop;
        end
        cpu_decode_pkg::OP_LOAD_DIR: begin
          dif.cls = cpu_decode_pkg::cl_load_dir;
          dif.len = cpu_decode_pkg::LEN_2;
        end
        cpu_decode_pkg::OP_XDATA_RD: begin
          dif.cls = cpu_decode_pkg::cl_xdata_read;
          dif.cyc = cpu_decode_pkg::MC_2;
        end
        cpu_decode_pkg::OP_SWAP_DIR: begin
          dif.cls = cpu_decode_pkg::cl_swap_dir;
          dif.len = cpu_decode_pkg::LEN_2;
        end
        cpu_decode_pkg::OP_BIT_INV: begin
          dif.cls = cpu_decode_pkg::cl_bit_inv;
          dif.len = cpu_decode_pkg::LEN_2;
        end
        cpu_decode_pkg::OP_BIT_TO_C: begin
          dif.cls = cpu_decode_pkg::cl_bit_to_c;
          dif.len = cpu_decode_pkg::LEN_2;
        end
        cpu_decode_pkg::OP_RET, cpu_decode_pkg::OP_INT_RET,
        cpu_decode_pkg::OP_JUMP_DATA_POINTER_16: begin
          dif.cls = (op == cpu_decode_pkg::OP_RET) ? cpu_decode_pkg::cl_ret :
                    (op == cpu_decode_pkg::OP_INT_RET) ?
                    cpu_decode_pkg::cl_interrupt_return :
                    cpu_decode_pkg::cl_jump_data_pointer_16;
          dif.cyc = cpu_decode_pkg::MC_2;
        end
        cpu_decode_pkg::OP_LONG_CALL, cpu_decode_pkg::OP_LONG_JUMP,
        cpu_decode_pkg::OP_BTC_BRANCH, cpu_decode_pkg::OP_DEC_BRANCH: begin
          dif.cls = (op == cpu_decode_pkg::OP_LONG_CALL) ?
                    cpu_decode_pkg::cl_long_call :
                    (op == cpu_decode_pkg::OP_LONG_JUMP) ?
                    cpu_decode_pkg::cl_long_jump :
                    (op == cpu_decode_pkg::OP_BTC_BRANCH) ?
                    cpu_decode_pkg::cl_bit_test_clear_branch :
                    cpu_decode_pkg::cl_decrement_branch_nonzero;
          dif.len = cpu_decode_pkg::LEN_3;
          dif.cyc = cpu_decode_pkg::MC_2;
        end
        default: begin
          dif.len = cpu_decode_pkg::LEN_2;
          dif.cyc = cpu_decode_pkg::MC_2;
          case (op)
            cpu_decode_pkg::OP_PUSH:       dif.cls = cpu_decode_pkg::cl_push;
            cpu_decode_pkg::OP_POP:        dif.cls = cpu_decode_pkg::cl_pop;
            cpu_decode_pkg::OP_AND_C:      dif.cls = cpu_decode_pkg::cl_and_c;
            cpu_decode_pkg::OP_AND_NC:     dif.cls = cpu_decode_pkg::cl_and_nc;
            cpu_decode_pkg::OP_OR_C:       dif.cls = cpu_decode_pkg::cl_or_c;
            cpu_decode_pkg::OP_OR_NC:      dif.cls = cpu_decode_pkg::cl_or_nc;
            cpu_decode_pkg::OP_C_TO_BIT:
              dif.cls = cpu_decode_pkg::cl_c_to_bit;
            cpu_decode_pkg::OP_SHORT_JUMP:
              dif.cls = cpu_decode_pkg::cl_short_jump;
            cpu_decode_pkg::OP_JUMP_ZERO:
              dif.cls = cpu_decode_pkg::cl_jump_zero;
            cpu_decode_pkg::OP_JUMP_NZ:
              dif.cls = cpu_decode_pkg::cl_jump_nonzero;
            default: begin
              dif.cls = cpu_decode_pkg::cl_other;
              dif.len = cpu_decode_pkg::LEN_1;
              dif.cyc = cpu_decode_pkg::MC_1;
            end
          endcase
        end
      endcase
    end
  end
endmodule : opcode_table
`default_nettype wire

// *** rtl/cpu_move_bool_branch_decode.sv ***
// Purpose: Fetch, decode and time move, bit and branch instructions
// Assumes: Program memory and operand sources run on clk
// Notes:   Datapath writes are requested through the *_we outputs
// How it works
// - E5 loads accumulator from direct byte: two bytes, one cycle
// - E6-E7 load accumulator through indirect pointer: one byte, one cycle
// - External read via data pointer into accumulator: one byte, two cycles
// - C0 pushes a direct byte: two bytes, two cycles
// - D0 pops into a direct byte: two bytes, two cycles
// - C5 swaps accumulator with direct byte: two bytes, one cycle
// - B2 inverts a direct bit: two bytes, one cycle
// - 82 and B0 AND bit or inverse into carry: two bytes, two cycles
// - 72 and A0 OR bit or inverse into carry: two bytes, two cycles
// - A2 bit to carry in one cycle, 92 carry to bit in two
// - Pattern 11 to F1 is absolute call: two bytes, two cycles
// - 12 is long call to sixteen-bit target: three bytes, two cycles
// - 22 returns from subroutine using stacked address: one byte, two
// - 32 returns from interrupt: one byte, two cycles
// - Pattern 01 to E1 is absolute jump: two bytes, two cycles
// - 02 is long jump to sixteen-bit target: three bytes, two cycles
// - 80 is short relative jump: two bytes, two cycles
// - 10 branches when bit set and clears it: three bytes, two
// - 73 jumps to accumulator plus data pointer: one byte, two cycles
// - 60 branches on zero accumulator, 70 on nonzero: two bytes
// - B8-BF compare bank register, branch if unequal: three bytes, two
// - D5 decrements direct byte, branch if nonzero: three bytes, two
// - One machine cycle is exactly two clocks
// - Low three opcode bits select the bank register
// - Upper three opcode bits are top of eleven-bit destination
`timescale 1ns/10ps
`default_nettype none
module cpu_move_bool_branch_decode (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   code_valid,
  input  wire logic [7:0]             code_byte,
  input  wire logic [7:0]             acc_in,
  input  wire logic                   carry_in,
  input  wire logic                   bit_in,
  input  wire logic [7:0]             data_in,
  input  wire logic [15:0]            data_pointer_16_in,
  input  wire logic [15:0]            ret_addr_in,
  output logic                        code_ready,
  output logic [15:0]                 pc,
  output cpu_decode_pkg::class_e      instr_class,
  output logic [1:0]                  instr_len,
  output logic [1:0]                  instr_cycles,
  output logic [2:0]                  reg_sel,
  output logic [7:0]                  arg1,
  output logic [7:0]                  arg2,
  output logic                        done,
  output logic                        branch_taken,
  output logic                        carry_out,
  output logic                        carry_we,
  output logic                        bit_out,
  output logic                        bit_we,
  output logic [7:0]                  data_out,
  output logic                        data_we
);

  // ----------------------------------------------------------------------
  // Decode lookup and machine cycle enable
  // ----------------------------------------------------------------------
  cpu_decode_pkg::state_e state;
  cpu_decode_pkg::state_e next_state;
  decode_if   dif ();
  logic [7:0]  opcode;
  logic [15:0] instr_pc;
  logic        arg_idx;
  logic [1:0]  mc_cnt;
  logic [2:0]  exec_clks;
  wire  logic  tick;

  assign dif.opcode = (state == cpu_decode_pkg::st_opcode) ? code_byte
                                                            : opcode;

  opcode_table u_table (
    .dif (dif)
  );

  mcycle_tick u_tick (
    .clk  (clk),
    .srst (srst),
    .run  (state == cpu_decode_pkg::st_exec),
    .tick (tick)
  );

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  wire logic take      = code_valid & code_ready;
  wire logic last_arg  = arg_idx | (instr_len == cpu_decode_pkg::LEN_2);
  wire logic last_mc   = tick & (mc_cnt == instr_cycles - 2'h1);

  always_comb begin
    next_state = state;
    case (state)
      cpu_decode_pkg::st_opcode: begin
        if (take) begin
          next_state = (dif.len == cpu_decode_pkg::LEN_1) ?
                       cpu_decode_pkg::st_exec : cpu_decode_pkg::st_args;
        end
      end
      cpu_decode_pkg::st_args: begin
        if (take && last_arg) begin
          next_state = cpu_decode_pkg::st_exec;
        end
      end
      cpu_decode_pkg::st_exec: begin
        if (last_mc) begin
          next_state = cpu_decode_pkg::st_opcode;
        end
      end
      default: next_state = cpu_decode_pkg::st_opcode;
    endcase
  end

  // ----------------------------------------------------------------------
  // Branch targets and results
  // ----------------------------------------------------------------------
  wire logic [15:0] seq_pc  = instr_pc + {14'h0, instr_len};
  wire logic [7:0]  rel     = (instr_len == cpu_decode_pkg::LEN_3) ? arg2
                                                                   : arg1;
  wire logic [15:0] rel_pc  = seq_pc + {{8{rel[7]}}, rel};
  wire logic [15:0] abs_pc  = {seq_pc[15:11], opcode[7:5], arg1};
  wire logic [15:0] long_pc = {arg1, arg2};
  wire logic [15:0] data_pointer_16_pc = data_pointer_16_in + {8'h0, acc_in};
  wire logic [7:0]  dec_val = data_in - 8'h01;
  logic             take_rel;
  logic [15:0]      next_pc;

  always_comb begin
    case (instr_class)
      cpu_decode_pkg::cl_short_jump:     take_rel = 1'b1;
      cpu_decode_pkg::cl_jump_zero:      take_rel = (acc_in == 8'h00);
      cpu_decode_pkg::cl_jump_nonzero:  take_rel = (acc_in != 8'h00);
      cpu_decode_pkg::cl_bit_test_clear_branch: take_rel = bit_in;
      cpu_decode_pkg::cl_compare_branch_unequal:
        take_rel = (data_in != arg1);
      cpu_decode_pkg::cl_decrement_branch_nonzero:
        take_rel = (data_in != cpu_decode_pkg::DECREMENT_BRANCH_NONZERO_LAST);
      default:                           take_rel = 1'b0;
    endcase
  end

  always_comb begin
    case (instr_class)
      cpu_decode_pkg::cl_absolute_call,
      cpu_decode_pkg::cl_absolute_jump:  next_pc = abs_pc;
      cpu_decode_pkg::cl_long_call,
      cpu_decode_pkg::cl_long_jump:      next_pc = long_pc;
      cpu_decode_pkg::cl_ret,
      cpu_decode_pkg::cl_interrupt_return:
        next_pc = ret_addr_in;
      cpu_decode_pkg::cl_jump_data_pointer_16:      next_pc = data_pointer_16_pc;
      default:                           next_pc = take_rel ? rel_pc
                                                            : seq_pc;
    endcase
  end

  wire logic is_carry_op = (instr_class == cpu_decode_pkg::cl_and_c) ||
                           (instr_class == cpu_decode_pkg::cl_and_nc) ||
                           (instr_class == cpu_decode_pkg::cl_or_c) ||
                           (instr_class == cpu_decode_pkg::cl_or_nc) ||
                           (instr_class == cpu_decode_pkg::cl_bit_to_c);
  wire logic carry_res =
    (instr_class == cpu_decode_pkg::cl_and_c)  ? (carry_in & bit_in) :
    (instr_class == cpu_decode_pkg::cl_and_nc) ? (carry_in & ~bit_in) :
    (instr_class == cpu_decode_pkg::cl_or_c)   ? (carry_in | bit_in) :
    (instr_class == cpu_decode_pkg::cl_or_nc)  ? (carry_in | ~bit_in) :
    bit_in;
  wire logic is_bit_op = (instr_class == cpu_decode_pkg::cl_bit_inv) ||
                         (instr_class == cpu_decode_pkg::cl_c_to_bit) ||
                         ((instr_class ==
                           cpu_decode_pkg::cl_bit_test_clear_branch) &&
                          bit_in);
  wire logic bit_res =
    (instr_class == cpu_decode_pkg::cl_bit_inv)  ? ~bit_in :
    (instr_class == cpu_decode_pkg::cl_c_to_bit) ? carry_in : 1'b0;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= cpu_decode_pkg::st_opcode;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      code_ready <= 1'b0;
    end else begin
      code_ready <= (next_state != cpu_decode_pkg::st_exec);
    end
  end

  // Opcode capture latches the decode so it stays stable during execute
  always_ff @(posedge clk) begin
    if (srst) begin
      opcode       <= cpu_decode_pkg::OP_NOP;
      instr_pc     <= cpu_decode_pkg::RESET_PC;
      instr_class  <= cpu_decode_pkg::cl_nop;
      instr_len    <= cpu_decode_pkg::LEN_1;
      instr_cycles <= cpu_decode_pkg::MC_1;
      reg_sel      <= 3'h0;
      arg_idx      <= 1'b0;
    end else if (take && state == cpu_decode_pkg::st_opcode) begin
      opcode       <= code_byte;
      instr_pc     <= pc;
      instr_class  <= dif.cls;
      instr_len    <= dif.len;
      instr_cycles <= dif.cyc;
      reg_sel      <= dif.reg_sel;
      arg_idx      <= 1'b0;
    end else if (take) begin
      arg_idx      <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      arg1 <= 8'h00;
      arg2 <= 8'h00;
    end else if (take && state == cpu_decode_pkg::st_args) begin
      if (arg_idx) begin
        arg2 <= code_byte;
      end else begin
        arg1 <= code_byte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state != cpu_decode_pkg::st_exec) begin
      mc_cnt <= 2'h0;
    end else if (tick) begin
      mc_cnt <= mc_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state != cpu_decode_pkg::st_exec) begin
      exec_clks <= 3'h0;
    end else begin
      exec_clks <= exec_clks + 3'h1;
    end
  end

  // Results land together with done, one clock after the last machine cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pc           <= cpu_decode_pkg::RESET_PC;
      done         <= 1'b0;
      branch_taken <= 1'b0;
      carry_we     <= 1'b0;
      bit_we       <= 1'b0;
      data_we      <= 1'b0;
      carry_out    <= 1'b0;
      bit_out      <= 1'b0;
      data_out     <= 8'h00;
    end else begin
      done         <= last_mc;
      branch_taken <= last_mc & take_rel;
      carry_we     <= last_mc & is_carry_op;
      bit_we       <= last_mc & is_bit_op;
      data_we      <= last_mc & (instr_class ==
                      cpu_decode_pkg::cl_decrement_branch_nonzero);
      if (last_mc) begin
        pc        <= next_pc;
        carry_out <= carry_res;
        bit_out   <= bit_res;
        data_out  <= dec_val;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  mc_length_a: assert property (done |-> exec_clks == {instr_cycles, 1'b0})
    else $error("execute length is not two clocks per machine cycle");

  load_dir_a: assert property (dif.opcode == cpu_decode_pkg::OP_LOAD_DIR |->
      dif.len == cpu_decode_pkg::LEN_2 && dif.cyc == cpu_decode_pkg::MC_1)
    else $error("direct load decoded with wrong size");

  cmp_reg_a: assert property (dif.opcode[7:3] == cpu_decode_pkg::OP_CMP_REG
      |-> dif.len == cpu_decode_pkg::LEN_3 && dif.reg_sel == dif.opcode[2:0])
    else $error("register compare decoded wrongly");

  long_jump_a: assert property (done &&
      instr_class == cpu_decode_pkg::cl_long_jump |-> pc == {arg1, arg2})
    else $error("long jump target wrong");

  abs_jump_a: assert property (done &&
      instr_class == cpu_decode_pkg::cl_absolute_jump |->
      pc[10:8] == opcode[7:5] && pc[7:0] == arg1)
    else $error("absolute jump target wrong");

  nop_step_a: assert property (done && instr_class == cpu_decode_pkg::cl_nop
      |-> pc == instr_pc + 16'h0001 && !carry_we && !bit_we && !data_we)
    else $error("no-op did not just step");

  rel_jump_a: assert property (done &&
      instr_class == cpu_decode_pkg::cl_short_jump |->
      pc == instr_pc + 16'h0002 + {{8{arg1[7]}}, arg1})
    else $error("short jump target wrong");

  btc_clear_a: assert property (done && branch_taken &&
      instr_class == cpu_decode_pkg::cl_bit_test_clear_branch |->
      bit_we && !bit_out)
    else $error("bit not cleared on taken branch");

  exec_hold_a: assert property ($rose(state == cpu_decode_pkg::st_exec) |->
      !code_ready ##1 !code_ready)
    else $error("fetch not stalled during execute");

endmodule : cpu_move_bool_branch_decode
`default_nettype wire

// *** test/prog_mem.sv ***
// Purpose: Program memory model feeding code bytes on request
// Assumes: Inputs from the bench change at the falling edge
// Notes:   Shows the inverse of the last byte while idle
`timescale 1ns/10ps
`default_nettype none
module prog_mem (
  input  wire logic        clk,
  input  wire logic        code_ready,
  input  wire logic        start,
  input  wire logic [23:0] bytes,
  input  wire logic [1:0]  n,
  output logic             code_valid,
  output logic [7:0]       code_byte
);
  logic [1:0] idx = 2'h0;
  logic [7:0] last = 8'h00;
  logic       tk = 1'b0;
  initial code_valid = 1'b0;
  initial code_byte = 8'h00;
  always @(posedge clk) tk <= code_valid && code_ready;
  always @(negedge clk) begin
    if (tk) last = code_byte;
    if (start) idx = 2'h0;
    else if (tk) idx = idx + 2'h1;
    code_valid = idx < n;
    code_byte = code_valid ? bytes[8*(2-idx) +: 8] : ~last;
  end
endmodule : prog_mem
`default_nettype wire

// *** test/cpu_move_bool_branch_decode_test.sv ***
// Purpose: Runs one opcode of every decoded class and checks class, length, time, pc
// Assumes: carry_in, bit_in and data_in derive from the row's acc
// Notes:   Table row is op, arg1, arg2, acc, class, length and cycles
`timescale 1ns/10ps
`default_nettype none
module cpu_move_bool_branch_decode_test;
  logic clk = 0, srst = 1, start = 0, cv, rdy, dn;
  logic [7:0] cb, acc = 8'h00;
  logic [15:0] dp = 16'h1234, ra = 16'h4321, pc, pe = 16'h0000;
  logic [23:0] by = 24'h000000;
  logic [1:0] n = 2'h0, ln, cy;
  logic [2:0] rs;
  logic [7:0] a1, a2, dout;
  logic bt, cwe, co, bwe, bo, dwe;
  wire logic [15:0] res = {2'h0, bt, cwe, cwe & co, bwe, bwe & bo, dwe,
                           dwe ? dout : 8'h00};
  cpu_decode_pkg::class_e cl;
  int err_total = 0, n_checks = 0, cnt;
  logic [47:0] t [32] = '{48'h000000_00_00_11, 48'he53000_00_01_21,
    48'he60000_00_02_11, 48'he70000_00_02_11, 48'hf00000_00_03_12,
    48'hc04000_00_04_22, 48'hd04100_00_05_22, 48'hc54200_00_06_21,
    48'hb22000_00_07_21, 48'h822100_01_08_22, 48'hb02100_03_09_22,
    48'h722100_00_0a_22, 48'ha02100_00_0b_22, 48'ha22100_02_0c_21,
    48'h922100_01_0d_22, 48'h315500_00_0e_22, 48'h121234_00_0f_32,
    48'h220000_00_10_12, 48'h320000_00_11_12, 48'he17f00_00_12_22,
    48'h02abcd_00_13_32, 48'h80fe00_00_14_22, 48'h102005_00_15_32,
    48'h730000_10_16_12, 48'h600800_00_17_22, 48'h700800_00_18_22,
    48'h70f000_05_18_22, 48'hba07f8_00_19_32, 48'hd54010_00_1a_32,
    48'h102005_02_15_32, 48'hba07f8_06_19_32,
    48'hd54010_04_1a_32};
  always #4 clk = ~clk;
  prog_mem pm_u (.clk(clk), .code_ready(rdy), .start(start), .bytes(by),
    .n(n), .code_valid(cv), .code_byte(cb));
  cpu_move_bool_branch_decode dut_u (.clk(clk), .srst(srst), .code_valid(cv),
    .code_byte(cb), .acc_in(acc), .carry_in(acc[0]), .bit_in(!acc[1]),
    .data_in(acc ^ 8'h01), .data_pointer_16_in(dp), .ret_addr_in(ra), .code_ready(rdy),
    .pc(pc), .instr_class(cl), .instr_len(ln), .instr_cycles(cy),
    .reg_sel(rs), .arg1(a1), .arg2(a2), .done(dn), .branch_taken(bt),
    .carry_out(co), .carry_we(cwe), .bit_out(bo), .bit_we(bwe),
    .data_out(dout), .data_we(dwe));
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Relative branch decision; data_in is acc ^ 01, bit_in is !acc[1]
  function logic tkr(input logic [7:0] o, a, ac);
    case (o)
      8'h80: tkr = 1'b1;
      8'h60: tkr = (ac == 8'h00);
      8'h70: tkr = (ac != 8'h00);
      8'h10: tkr = !ac[1];
      8'hba: tkr = ((ac ^ 8'h01) != a);
      8'hd5: tkr = ((ac ^ 8'h01) != 8'h01);
      default: tkr = 1'b0;
    endcase
  endfunction : tkr
  function logic [15:0] nxt(input logic [7:0] o, a, b, ac, input logic [1:0] l);
    logic [15:0] q;
    logic [7:0] r;
    q = pe + 16'(l);
    r = (l == 2'h3) ? b : a;
    case (o)
      8'h12, 8'h02: q = {a, b};
      8'h22, 8'h32: q = ra;
      8'h73: q = dp + 16'(ac);
      default: begin
        if (o[4:0] == 5'h11 || o[4:0] == 5'h01) q = {q[15:11], o[7:5], a};
        else if (tkr(o, a, ac)) q = q + {{8{r[7]}}, r};
      end
    endcase
    return q;
  endfunction : nxt
  // Expected {taken, carry we/value, bit we/value, data we/value}
  function logic [15:0] fx(input int i);
    logic c, b;
    logic [7:0] o, d;
    o = t[i][47:40];
    c = t[i][16];
    b = !t[i][17];
    d = t[i][23:16] ^ 8'h01;
    fx = {2'h0, tkr(o, t[i][39:32], t[i][23:16]), 13'h0};
    case (o)
      8'h82: fx[12:11] = {1'b1, c & b};
      8'hb0: fx[12:11] = {1'b1, c & !b};
      8'h72: fx[12:11] = {1'b1, c | b};
      8'ha0: fx[12:11] = {1'b1, c | !b};
      8'ha2: fx[12:11] = {1'b1, b};
      8'hb2: fx[10:9] = {1'b1, !b};
      8'h92: fx[10:9] = {1'b1, c};
      8'h10: fx[10:9] = {b, 1'b0};
      8'hd5: fx[8:0] = {1'b1, d - 8'h01};
      default: fx = fx;
    endcase
  endfunction : fx
  task print_verdict;
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task run_table;
    logic [15:0] m;
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      by <= t[i][47:24];
      acc <= t[i][23:16];
      n <= t[i][5:4];
      start <= 1'b1;
      @(negedge clk);
      start <= 1'b0;
      cnt = 0;
      while (dn !== 1'b1 && cnt < 40) begin
        @(negedge clk);
        cnt++;
      end
      chk(16'(cl), {8'h00, t[i][15:8]});
      chk({10'h0, ln, 2'h0, cy}, {10'h0, t[i][5:4], 2'h0, t[i][1:0]});
      chk(16'(cnt), 16'(t[i][5:4]) + 16'(2 * t[i][1:0]));
      chk({13'h0, rs}, {13'h0, t[i][42:40]});
      pe = nxt(t[i][47:40], t[i][39:32], t[i][31:24], t[i][23:16], t[i][5:4]);
      chk(pc, pe);
      chk(res, fx(i));
      m = {{8{t[i][5]}}, {8{t[i][5:4] == 2'h3}}};
      chk(m & {a1, a2}, m & t[i][39:24]);
    end
  endtask : run_table
  initial begin
    repeat (10) @(negedge clk);
    srst <= 1'b0;
    run_table();
    print_verdict();
  end
  initial begin
    #40000;
    err_total++;
    print_verdict();
  end
endmodule : cpu_move_bool_branch_decode_test
`default_nettype wire
